// ---- rtl/dsl_top.sv ----
// Summary of operation
// R1: reset disables loop, pin source, nrzi mode
// R2: enter-search command enables the recovery loop
// R3: software picks source, mode, then enables
// R4: loop not free running; lost data re-searches
// R5: transmit clock best from a continuous source
// R6: loop reference at most half bus clock from pin, one tick per clock from brg
// R7: loopback feeds transmitter into receiver, pin kept
// R8: loopback ignores carrier and cts enables
// R9: loop input stays on receive pin
// R10: echo drives transmit pin from receive pin
// R11: echo ignores cts, transmitter output dropped
// R12: both bits: echo routing, both enables ignored
// R13: search holds bit-cell counter at sixteen
// R14: disabled or nrzi clears missing-clock flags
// R15: routing follows register bits next cycle
`timescale 1ns/1ps
module dsl_top (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dsl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic                            pready,
   output logic [31:0]                     prdata,
   output logic                            pslverr,
   input  wire logic                       shared_clock_pin,
   input  wire logic                       rx_pin,
   input  wire logic                       cts_in,
   input  wire logic                       carrier_detect_in,
   input  wire logic                       brg_tick,
   input  wire logic                       xmtr_data,
   input  wire logic                       rcvr_req,
   input  wire logic                       xmtr_req,
   output logic                            tx_pin,
   output logic                            rcvr_data,
   output logic                            rcvr_enable,
   output logic                            xmtr_enable,
   output logic                            rec_rx_clk,
   output logic                            rec_tx_clk
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [dsl_pkg::SYNC_W-1:0] sync_q;
   logic                       ref_s;
   logic                       rx_s;
   logic                       cts_s;
   logic                       cd_s;

   dsl_sync u_sync (
      .mclk    (mclk),
      .rst     (rst),
      .d_async ({carrier_detect_in, cts_in, rx_pin, shared_clock_pin}),
      .q       (sync_q)
   );

   assign ref_s = sync_q[dsl_pkg::SYNC_CLK];
   assign rx_s  = sync_q[dsl_pkg::SYNC_RX];
   assign cts_s = sync_q[dsl_pkg::SYNC_CTS];
   assign cd_s  = sync_q[dsl_pkg::SYNC_CD];

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   dsl_pkg::dsl_state_t s;
   dsl_pkg::dsl_state_t next_s;

   logic             acc;
   logic             wr;
   logic             wr_misc;
   logic             wr_chan;
   dsl_pkg::dsl_cmd_t cmd;
   logic             chan_rst;
   logic             ref_tick;
   logic             data_edge;
   logic             hit;
   logic             in_win;
   logic             seen_now;
   logic             set_one;
   logic             set_two;

   assign acc       = psel & penable;
   assign wr        = acc & s.pready & pwrite;
   assign wr_misc   = wr & (paddr == dsl_pkg::MISC_CONTROL_OFS);
   assign wr_chan   = wr & (paddr == dsl_pkg::CHAN_CONTROL_OFS);
   assign cmd       = wr_misc ?
                      dsl_pkg::dsl_cmd_t'(pwdata[dsl_pkg::CMD_MSB:
                                                 dsl_pkg::CMD_LSB]) :
                      dsl_pkg::CMD_NULL;
   assign chan_rst  = wr_chan & pwdata[dsl_pkg::CHAN_RESET_BIT];
   // the loop advances on rising edges of the pin reference, or on each brg tick
   assign ref_tick  = s.src_brg ? brg_tick : (ref_s & ~s.ref_prev);
   assign data_edge = rx_s ^ s.rx_prev;               // see R9
   assign hit       = s.edge_pend | data_edge;
   assign in_win    = (s.cnt >= dsl_pkg::WIN_LO) &&
                      (s.cnt <= dsl_pkg::WIN_HI);
   assign seen_now  = s.seen_edge | (hit & (~s.mode_fm | in_win));

   always_comb begin
      next_s  = s;
      set_one = 1'b0;
      set_two = 1'b0;

      // ---------------------------------------------------------------
      // apb slave: one wait state, error on unmapped address
      // ---------------------------------------------------------------
      next_s.pready  = acc & ~s.pready;
      next_s.pslverr = 1'b0;
      if (acc & ~s.pready) begin
         next_s.prdata = '0;
         case (paddr)
            dsl_pkg::MISC_CONTROL_OFS: begin
               next_s.prdata[dsl_pkg::LOOPBACK_BIT] = s.loopback;
               next_s.prdata[dsl_pkg::ECHO_BIT]     = s.echo;
            end
            dsl_pkg::MISC_STATUS_OFS: begin
               next_s.prdata[dsl_pkg::STS_ENABLED_BIT] =
                  (s.loop_state != dsl_pkg::ST_OFF);
               next_s.prdata[dsl_pkg::STS_SEARCH_BIT]  =
                  (s.loop_state != dsl_pkg::ST_TRACK);
               next_s.prdata[dsl_pkg::STS_SRC_BIT]     = s.src_brg;
               next_s.prdata[dsl_pkg::STS_FM_BIT]      = s.mode_fm;
               next_s.prdata[dsl_pkg::STS_ONE_BIT]     = s.one_miss;
               next_s.prdata[dsl_pkg::STS_TWO_BIT]     = s.two_miss;
            end
            dsl_pkg::CHAN_CONTROL_OFS: begin
               next_s.prdata[dsl_pkg::AUTO_EN_BIT] = s.auto_en;
            end
            default: begin
               next_s.pslverr = 1'b1;
            end
         endcase
      end

      if (wr_misc) begin
         next_s.loopback = pwdata[dsl_pkg::LOOPBACK_BIT];    // see R15
         next_s.echo     = pwdata[dsl_pkg::ECHO_BIT];        // see R15
      end
      if (wr_chan) begin
         next_s.auto_en = pwdata[dsl_pkg::AUTO_EN_BIT];
      end

      // ---------------------------------------------------------------
      // clock recovery loop
      // ---------------------------------------------------------------
      next_s.rx_prev   = rx_s;
      next_s.ref_prev  = ref_s;
      next_s.edge_pend = s.edge_pend | data_edge;
      case (s.loop_state)
         dsl_pkg::ST_OFF: begin
            next_s.cnt       = dsl_pkg::SEARCH_COUNT;   // see R13
            next_s.edge_pend = 1'b0;
         end
         dsl_pkg::ST_SEARCH: begin
            // no free running here; first line edge starts tracking
            next_s.cnt       = dsl_pkg::SEARCH_COUNT;   // see R4, R13
            next_s.edge_pend = 1'b0;
            if (data_edge) begin                         // see R9
               next_s.loop_state  = dsl_pkg::ST_TRACK;
               next_s.seen_edge   = 1'b0;
               next_s.missed_once = 1'b0;
            end
         end
         dsl_pkg::ST_TRACK: begin
            if (ref_tick) begin                          // see R6
               next_s.edge_pend = 1'b0;
               next_s.seen_edge = seen_now;
               if (s.cnt == dsl_pkg::CNT_LAST) begin
                  next_s.cnt       = dsl_pkg::CNT_ZERO;
                  next_s.seen_edge = 1'b0;
                  if (seen_now) begin
                     next_s.missed_once = 1'b0;
                  end else if (s.missed_once) begin
                     // second empty cycle: sync lost
                     set_one            = s.mode_fm;
                     set_two            = s.mode_fm;
                     next_s.missed_once = 1'b0;
                     next_s.loop_state  = dsl_pkg::ST_SEARCH; // see R4
                     next_s.cnt         = dsl_pkg::SEARCH_COUNT;
                  end else begin
                     set_one            = s.mode_fm;
                     next_s.missed_once = 1'b1;
                  end
               end else begin
                  next_s.cnt = s.cnt + dsl_pkg::CNT_ONE;
               end
            end
         end
         default: begin
            next_s.loop_state = dsl_pkg::ST_OFF;
            next_s.cnt        = dsl_pkg::SEARCH_COUNT;
         end
      endcase

      // clear first so a flag event in the same cycle still lands
      if (cmd == dsl_pkg::CMD_RESET_MISSING) begin
         next_s.one_miss = 1'b0;
         next_s.two_miss = 1'b0;
      end
      if (set_one) begin
         next_s.one_miss = 1'b1;
      end
      if (set_two) begin
         next_s.two_miss = 1'b1;
      end

      // ---------------------------------------------------------------
      // commands; channel reset wins over everything
      // ---------------------------------------------------------------
      case (cmd)
         dsl_pkg::CMD_ENTER_SEARCH: begin
            next_s.loop_state  = dsl_pkg::ST_SEARCH;      // see R2
            next_s.cnt         = dsl_pkg::SEARCH_COUNT;
            next_s.missed_once = 1'b0;
            next_s.one_miss    = 1'b0;
            next_s.two_miss    = 1'b0;
         end
         dsl_pkg::CMD_DISABLE: begin
            next_s.loop_state = dsl_pkg::ST_OFF;
            next_s.cnt        = dsl_pkg::SEARCH_COUNT;
         end
         dsl_pkg::CMD_SRC_BRG:   next_s.src_brg = 1'b1;
         dsl_pkg::CMD_SRC_PIN:   next_s.src_brg = 1'b0;
         dsl_pkg::CMD_MODE_FM:   next_s.mode_fm = 1'b1;
         dsl_pkg::CMD_MODE_NRZI: next_s.mode_fm = 1'b0;
         default: begin
         end
      endcase
      if (chan_rst) begin
         next_s.loop_state  = dsl_pkg::ST_OFF;            // see R1
         next_s.src_brg     = 1'b0;                       // see R1
         next_s.mode_fm     = 1'b0;                       // see R1
         next_s.cnt         = dsl_pkg::SEARCH_COUNT;
         next_s.missed_once = 1'b0;
      end
      if ((next_s.loop_state == dsl_pkg::ST_OFF) || !next_s.mode_fm) begin
         next_s.one_miss = 1'b0;                          // see R14
         next_s.two_miss = 1'b0;                          // see R14
      end

      // clock outputs from the counter; count 16 gives idle levels
      if (s.mode_fm) begin
         next_s.rclk = ~next_s.cnt[dsl_pkg::CNT_MSB];
         next_s.tclk = ~(next_s.cnt[dsl_pkg::CNT_MSB] ^
                         next_s.cnt[dsl_pkg::CNT_NEXT_MSB]);
      end else begin
         next_s.rclk = next_s.cnt[dsl_pkg::CNT_MSB];
         next_s.tclk = next_s.cnt[dsl_pkg::CNT_MSB];
      end

      // ---------------------------------------------------------------
      // diagnostic routing, registered once for clean pin timing
      // ---------------------------------------------------------------
      next_s.tx_pin    = s.echo ? rx_s : xmtr_data;       // see R7, R10
      next_s.rcvr_data = (s.loopback && !s.echo) ?
                         xmtr_data : rx_s;                // see R7, R10, R12
      next_s.rcvr_en   = rcvr_req &
                         (~s.auto_en | s.loopback | cd_s);// see R8, R12
      next_s.xmtr_en   = xmtr_req &
                         (~s.auto_en | s.loopback | s.echo |
                          cts_s);                         // see R8, R11, R12
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= dsl_pkg::STATE_RST;                         // see R1
      end else begin
         s <= next_s;
      end
   end

   assign pready      = s.pready;
   assign prdata      = s.prdata;
   assign pslverr     = s.pslverr;
   assign tx_pin      = s.tx_pin;
   assign rcvr_data   = s.rcvr_data;
   assign rcvr_enable = s.rcvr_en;
   assign xmtr_enable = s.xmtr_en;
   assign rec_rx_clk  = s.rclk;
   assign rec_tx_clk  = s.tclk;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   sequence s_loop_write;
      wr_misc && pwdata[dsl_pkg::LOOPBACK_BIT] && !pwdata[dsl_pkg::ECHO_BIT];
   endsequence

   sequence s_search_cmd;
      (cmd == dsl_pkg::CMD_ENTER_SEARCH) && !chan_rst;
   endsequence

   property p_reset_state;
      @(posedge mclk) rst |=> (s.loop_state == dsl_pkg::ST_OFF) &&
                              !s.src_brg && !s.mode_fm;
   endproperty
   a_reset_state: assert property (p_reset_state)   // see R1
      else $error("reset left recovery loop configured");

   property p_enter_search;
      @(posedge mclk) disable iff (rst)
      s_search_cmd |=> (s.loop_state == dsl_pkg::ST_SEARCH) &&
                       !s.one_miss && !s.two_miss;
   endproperty
   a_enter_search: assert property (p_enter_search) // see R2
      else $error("enter search command did not enable loop");

   property p_search_count;
      @(posedge mclk) disable iff (rst)
      (s.loop_state != dsl_pkg::ST_TRACK) |->
         (s.cnt == dsl_pkg::SEARCH_COUNT);
   endproperty
   a_search_count: assert property (p_search_count) // see R13
      else $error("counter not at sixteen outside tracking");

   property p_flags_clear;
      @(posedge mclk) disable iff (rst)
      ((s.loop_state == dsl_pkg::ST_OFF) || !s.mode_fm) |->
         !s.one_miss && !s.two_miss;
   endproperty
   a_flags_clear: assert property (p_flags_clear)   // see R14
      else $error("missing clock flag set while off or nrzi");

   property p_lost_sync;
      @(posedge mclk) disable iff (rst)
      $rose(s.two_miss) |-> (s.loop_state == dsl_pkg::ST_SEARCH) &&
                            s.one_miss;
   endproperty
   a_lost_sync: assert property (p_lost_sync)       // see R4
      else $error("two missing clocks without search");

   property p_loop_write;
      @(posedge mclk) disable iff (rst)
      s_loop_write |=> s.loopback ##1
         (rcvr_data == $past(xmtr_data)) && (tx_pin == $past(xmtr_data));
   endproperty
   a_loop_write: assert property (p_loop_write)     // see R7, R15
      else $error("loopback routing late or wrong");

   property p_echo_route;
      @(posedge mclk) disable iff (rst)
      s.echo |=> (tx_pin == $past(rx_s)) && (rcvr_data == $past(rx_s));
   endproperty
   a_echo_route: assert property (p_echo_route)     // see R10, R11
      else $error("echo routing wrong");

   property p_cts_ignored;
      @(posedge mclk) disable iff (rst)
      (s.loopback || s.echo) && xmtr_req |=> xmtr_enable;
   endproperty
   a_cts_ignored: assert property (p_cts_ignored)   // see R8, R11
      else $error("cts gated transmitter in diagnostic mode");

   property p_cd_ignored;
      @(posedge mclk) disable iff (rst)
      s.loopback && rcvr_req |=> rcvr_enable;
   endproperty
   a_cd_ignored: assert property (p_cd_ignored)     // see R8, R12
      else $error("carrier gated receiver in loopback");

   property p_loop_input;
      @(posedge mclk) disable iff (rst)
      s.loopback && (s.loop_state == dsl_pkg::ST_SEARCH) &&
      (rx_s != s.rx_prev) && (cmd == dsl_pkg::CMD_NULL) && !chan_rst
         |=> (s.loop_state == dsl_pkg::ST_TRACK);
   endproperty
   a_loop_input: assert property (p_loop_input)     // see R9
      else $error("loop did not follow receive pin");

endmodule : dsl_top

// ---- rtl/dsl_pkg.sv ----
package dsl_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses on apb)
   // ------------------------------------------------------------------
   localparam int          ADDR_W           = 12;
   localparam logic [11:0] MISC_CONTROL_OFS = 12'h000;
   localparam logic [11:0] MISC_STATUS_OFS  = 12'h004;
   localparam logic [11:0] CHAN_CONTROL_OFS = 12'h008;

   // misc_control_reg fields
   localparam int ECHO_BIT     = 3;
   localparam int LOOPBACK_BIT = 4;
   localparam int CMD_LSB      = 5;
   localparam int CMD_MSB      = 7;

   // chan control fields
   localparam int CHAN_RESET_BIT = 0;
   localparam int AUTO_EN_BIT    = 1;

   // misc_status_reg fields
   localparam int STS_ENABLED_BIT = 0;
   localparam int STS_SEARCH_BIT  = 1;
   localparam int STS_SRC_BIT     = 2;
   localparam int STS_FM_BIT      = 3;
   localparam int STS_ONE_BIT     = 6;
   localparam int STS_TWO_BIT     = 7;

   // ------------------------------------------------------------------
   // bit-cell counter
   // ------------------------------------------------------------------
   localparam int         CNT_W        = 5;
   localparam int         CNT_MSB      = 4;
   localparam int         CNT_NEXT_MSB = 3;
   localparam logic [4:0] SEARCH_COUNT = 5'h10;
   localparam logic [4:0] WIN_LO       = 5'h0c;
   localparam logic [4:0] WIN_HI       = 5'h13;
   localparam logic [4:0] CNT_LAST     = 5'h1f;
   localparam logic [4:0] CNT_ZERO     = 5'h00;
   localparam logic [4:0] CNT_ONE      = 5'h01;

   // ------------------------------------------------------------------
   // synchroniser lanes
   // ------------------------------------------------------------------
   localparam int SYNC_W   = 4;
   localparam int SYNC_CLK = 0;
   localparam int SYNC_RX  = 1;
   localparam int SYNC_CTS = 2;
   localparam int SYNC_CD  = 3;

   typedef enum logic [2:0] {
      CMD_NULL          = 3'h0,
      CMD_ENTER_SEARCH  = 3'h1,
      CMD_RESET_MISSING = 3'h2,
      CMD_DISABLE       = 3'h3,
      CMD_SRC_BRG       = 3'h4,
      CMD_SRC_PIN       = 3'h5,
      CMD_MODE_FM       = 3'h6,
      CMD_MODE_NRZI     = 3'h7
   } dsl_cmd_t;

   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_SEARCH = 2'b01,
      ST_TRACK  = 2'b10
   } dsl_loop_state_t;

   typedef struct packed {
      logic            loopback;
      logic            echo;
      logic            auto_en;
      logic            src_brg;
      logic            mode_fm;
      dsl_loop_state_t loop_state;
      logic [4:0]      cnt;
      logic            edge_pend;
      logic            seen_edge;
      logic            missed_once;
      logic            one_miss;
      logic            two_miss;
      logic            rx_prev;
      logic            ref_prev;
      logic            tx_pin;
      logic            rcvr_data;
      logic            rcvr_en;
      logic            xmtr_en;
      logic            rclk;
      logic            tclk;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
   } dsl_state_t;

   localparam dsl_state_t STATE_RST = '{loop_state: ST_OFF,
                                        cnt:        SEARCH_COUNT,
                                        rclk:       1'b1,
                                        tclk:       1'b1,
                                        default:    '0};

endpackage : dsl_pkg

// ---- rtl/dsl_sync.sv ----
`timescale 1ns/1ps
module dsl_sync (
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic [dsl_pkg::SYNC_W-1:0] d_async,
   output logic      [dsl_pkg::SYNC_W-1:0] q
);

   typedef struct packed {
      logic [dsl_pkg::SYNC_W-1:0] meta;
      logic [dsl_pkg::SYNC_W-1:0] stable;
   } dsl_sync_state_t;

   dsl_sync_state_t s;
   dsl_sync_state_t next_s;

   // first stage feeds the second stage only
   always_comb begin
      next_s        = s;
      next_s.meta   = d_async;
      next_s.stable = s.meta;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.stable;

endmodule : dsl_sync

// ---- testbench/dsl_line_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// far-side serial line and modem controls
// ----------------------------------------
module dsl_line_model (
   input  wire logic mclk,
   input  wire logic clk_run,
   input  wire logic rx_val,
   input  wire logic cts_val,
   input  wire logic cd_val,
   output logic      shared_clock_pin,
   output logic      rx_pin,
   output logic      cts_in,
   output logic      carrier_detect_in
);
   logic [2:0] div;
   initial div = 3'h0;
   // mclk/8 keeps every reference edge visible to the sampler
   always @(posedge mclk) begin
      div <= clk_run ? div + 3'h1 : 3'h0;
   end
   // reference stands low outside frames
   assign shared_clock_pin  = div[2];
   assign rx_pin            = rx_val;
   assign cts_in            = cts_val;
   assign carrier_detect_in = cd_val;
endmodule : dsl_line_model

// ---- testbench/tb_dsl_top.sv ----
`timescale 1ns/1ps
module tb_dsl_top;
   logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, err, brg_tick = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        xmtr_data = 1'b0, rcvr_req = 1'b0, xmtr_req = 1'b0;
   logic        tx_pin, rcvr_data, rcvr_enable, xmtr_enable;
   logic        rec_rx_clk, rec_tx_clk, shared_clock_pin, rx_pin;
   logic        cts_in, carrier_detect_in, clk_run = 1'b0;
   logic        rx_val = 1'b0, cts_val = 1'b0, cd_val = 1'b0;
   logic [5:0]  r;
   int          fails = 0, num_checks = 0, seed = 17918;
   int          m_lb = 0, m_ec = 0;

   always #20 mclk = ~mclk;

   // baud generator stand-in: a tick every other clock while line runs
   always @(posedge mclk) brg_tick <= clk_run & ~brg_tick;

   dsl_top i_dsl_top (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .shared_clock_pin(shared_clock_pin), .rx_pin(rx_pin),
      .cts_in(cts_in), .carrier_detect_in(carrier_detect_in),
      .brg_tick(brg_tick), .xmtr_data(xmtr_data), .rcvr_req(rcvr_req),
      .xmtr_req(xmtr_req), .tx_pin(tx_pin), .rcvr_data(rcvr_data),
      .rcvr_enable(rcvr_enable), .xmtr_enable(xmtr_enable),
      .rec_rx_clk(rec_rx_clk), .rec_tx_clk(rec_tx_clk));

   dsl_line_model i_dsl_line_model (.mclk(mclk), .clk_run(clk_run),
      .rx_val(rx_val), .cts_val(cts_val), .cd_val(cd_val),
      .shared_clock_pin(shared_clock_pin), .rx_pin(rx_pin),
      .cts_in(cts_in), .carrier_detect_in(carrier_detect_in));

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // command and routing bits share one write
   task cmd(input int c);
      apb(1'b1, dsl_pkg::MISC_CONTROL_OFS,
          32'((c << dsl_pkg::CMD_LSB) | (m_lb << 4) | (m_ec << 3)));
   endtask : cmd

   task sts(input int en, srch, src, fm, miss);
      apb(1'b0, dsl_pkg::MISC_STATUS_OFS, 32'h0);
      chk("status", rd, 32'((en << dsl_pkg::STS_ENABLED_BIT)
          | (srch << dsl_pkg::STS_SEARCH_BIT)
          | (src << dsl_pkg::STS_SRC_BIT) | (fm << dsl_pkg::STS_FM_BIT)
          | (miss << dsl_pkg::STS_ONE_BIT) | (miss << dsl_pkg::STS_TWO_BIT)));
   endtask : sts

   // lose lock: one data edge, then a running reference with a silent line
   task lose_lock(input int fm, src);
      rx_val <= ~rx_val;
      repeat (6) @(posedge mclk);
      sts(1, 0, src, fm, 0);
      clk_run <= 1'b1;
      repeat (700) @(posedge mclk);
      clk_run <= 1'b0;
   endtask : lose_lock

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      finish_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      sts(0, 1, 0, 0, 0);
      chk("rec clocks", {rec_rx_clk, rec_tx_clk}, 2'b11);
      apb(1'b0, 12'h00c, 32'h0);
      chk("slverr", err, 1'b1);
      chk("unmapped", rd, 32'h0);
      apb(1'b1, dsl_pkg::CHAN_CONTROL_OFS, 32'h2);
      for (int m = 0; m < 8; m++) begin
         m_lb = m % 2;
         m_ec = (m / 2) % 2;
         // second half runs with automatic enables switched off
         if (m == 4) apb(1'b1, dsl_pkg::CHAN_CONTROL_OFS, 32'h0);
         cmd(0);
         apb(1'b0, dsl_pkg::MISC_CONTROL_OFS, 32'h0);
         chk("misc", rd, 32'(m_lb * 16 + m_ec * 8));
         // transmit data paced by mclk, a continuous clock
         repeat (6) begin
            r = 6'($random(seed));
            {rx_val, xmtr_data, cts_val, cd_val, rcvr_req, xmtr_req} <= r;
            repeat (5) @(posedge mclk);
            chk("tx_pin", tx_pin, m_ec ? rx_val : xmtr_data);
            chk("rcvr_data", rcvr_data,
                (m_lb && !m_ec) ? xmtr_data : rx_val);
            chk("rcvr_en", rcvr_enable,
                rcvr_req & (m >= 4 || m_lb != 0 || cd_val));
            chk("xmtr_en", xmtr_enable, xmtr_req & (m >= 4 || m_lb != 0
                || m_ec != 0 || cts_val));
         end
      end
      m_lb = 0;
      m_ec = 0;
      cmd(3);
      cmd(6);
      cmd(1);
      sts(1, 1, 0, 1, 0);
      chk("fm search clk", {rec_rx_clk, rec_tx_clk}, 2'b00);
      lose_lock(1, 0);
      sts(1, 1, 0, 1, 1);
      // loop must still lock on the pin while looped back
      m_lb = 1;
      cmd(7);
      sts(1, 1, 0, 0, 0);
      lose_lock(0, 0);
      sts(1, 1, 0, 0, 0);
      chk("nrzi search clk", {rec_rx_clk, rec_tx_clk}, 2'b11);
      m_lb = 0;
      // source, then mode, then enable
      cmd(4);
      cmd(6);
      cmd(1);
      sts(1, 1, 1, 1, 0);
      lose_lock(1, 1);
      sts(1, 1, 1, 1, 1);
      apb(1'b1, dsl_pkg::CHAN_CONTROL_OFS, 32'h3);
      sts(0, 1, 0, 0, 0);
      finish_test();
   end
endmodule : tb_dsl_top
